// >>> hw/ccr_pkg.sv
// Shared constants, types and ratio decode for the core clock ratio and reset block
package ccr_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS   = 100;
    localparam int PLL_SETTLE_NS   = 10000;
    localparam int PLL_SETTLE_CYC  = (PLL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // Strap and multiplier layout
    // ------------------------------------------------------------
    localparam int STRAP_W         = 3;
    localparam int STRAP_MSB_POS   = 2;
    localparam int MULT_W          = 4;
    localparam int REV_W           = 8;
    localparam int MAX_MULT        = 8;

    // Reset values
    localparam logic [STRAP_W-1:0] STRAP_RST = 3'h0;
    localparam logic [REV_W-1:0]   REV_RST   = 8'h00;
    localparam logic [MULT_W-1:0]  MULT_RST  = 4'h4;

    // Revision groups of the identity register
    typedef enum logic [1:0] {
        CCR_GRP_EARLY,
        CCR_GRP_MIDDLE,
        CCR_GRP_LATE
    } ccr_grp_t;

    // Test-only encoding of the straps
    localparam logic [STRAP_W-1:0] STRAP_TEST = 3'h0;

    // Strap code to core multiplier, per revision group
    function automatic logic [MULT_W-1:0] ccr_decode(input ccr_grp_t grp,
                                                     input logic [STRAP_W-1:0] code);
        logic [MULT_W-1:0] m;
        m = MULT_RST;
        case (grp)
            CCR_GRP_EARLY: begin
                case (code[1:0])
                    2'h0:    m = 4'h4;
                    2'h1:    m = 4'h6;
                    2'h2:    m = 4'h7;
                    default: m = 4'h5;
                endcase
            end
            CCR_GRP_MIDDLE: begin
                case (code[1:0])
                    2'h0:    m = 4'h4;
                    2'h1:    m = 4'h6;
                    2'h2:    m = 4'h7;
                    default: m = 4'h8;
                endcase
            end
            default: begin
                case (code)
                    3'h0:    m = 4'h4;
                    3'h1:    m = 4'hA;
                    3'h2:    m = 4'h9;
                    3'h3:    m = 4'h5;
                    3'h4:    m = 4'h4;
                    3'h5:    m = 4'h6;
                    3'h6:    m = 4'h7;
                    default: m = 4'h8;
                endcase
            end
        endcase
        return m;
    endfunction

endpackage

// >>> hw/ccr_mem_if.sv
// Port bundle between the controller and the cache valid-bit store
`timescale 1ns/1ps
`default_nettype none
interface ccr_mem_if #(parameter int AW = 6);
    logic          we;
    logic [AW-1:0] waddr;
    logic          wdata;
    logic [AW-1:0] raddr;
    logic          rdata;

    // Controller side
    modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
    // Store side
    modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// >>> hw/ccr_valid_mem.sv
// Cache line valid-bit store with registered read data
`timescale 1ns/1ps
`default_nettype none
module ccr_valid_mem #(
    parameter int LINES = 64,
    parameter int AW    = 6
) (
    // Clock and reset
    input  wire logic i_clk,
    input  wire logic i_resetn,
    // Access port
    ccr_mem_if.mem    bus
);

    logic [LINES-1:0] valid;

    // ------------------------------------------------------------
    // Storage and read register
    // ------------------------------------------------------------
    // Write one entry per cycle
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            valid <= '0;
        end else if (bus.we) begin
            valid[bus.waddr] <= bus.wdata;
        end
    end

    // Registered read data
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            bus.rdata <= 1'b0;
        end else begin
            bus.rdata <= valid[bus.raddr];
        end
    end

endmodule // ccr_valid_mem
`default_nettype wire

// >>> hw/ccr_top.sv
// Core clock ratio selection and reset sequencing
`timescale 1ns/1ps
`default_nettype none
module ccr_top
    import ccr_pkg::*;
#(
    parameter int               CACHE_LINES = 64,
    parameter int               CACHE_AW    = 6,
    parameter logic [REV_W-1:0] REV_MID_MIN  = 8'h20, // Arbitrary value
    parameter logic [REV_W-1:0] REV_LATE_MIN = 8'h40  // Arbitrary value
) (
    // Clock and block reset
    input  wire logic                i_clk,
    input  wire logic                i_resetn,
    // Reset pin, asynchronous, active high
    input  wire logic                i_reset_pin,
    // Straps and identity
    input  wire logic [STRAP_W-1:0]  i_core_ratio_straps,
    input  wire logic [REV_W-1:0]    i_device_identity_reg,
    // PLL status
    input  wire logic                i_pll_locked,
    // Cache valid-bit access
    input  wire logic                i_fill_we,
    input  wire logic [CACHE_AW-1:0] i_fill_idx,
    input  wire logic [CACHE_AW-1:0] i_lookup_idx,
    // PLL control
    output logic [MULT_W-1:0]        o_pll_mult,
    output logic                     o_pll_ratio_test,
    output logic                     o_pci_ref_sel,
    // Reset outputs, active low
    output logic                     o_core_resetn,
    output logic                     o_periph_resetn,
    // Cache status
    output logic                     o_inval_busy,
    output var logic                 o_lookup_valid
);

    typedef enum logic [1:0] {
        ST_INVAL,
        ST_HOLD,
        ST_SETTLE,
        ST_RUN
    } ccr_state_t;

    localparam logic [7:0]          SETTLE_LAST = 8'(PLL_SETTLE_CYC - 1);
    localparam logic [CACHE_AW-1:0] IDX_LAST    = CACHE_AW'(CACHE_LINES - 1);

    ccr_state_t          state;
    ccr_state_t          next_state;
    logic                rst_meta;
    logic                rst_sync;
    logic [STRAP_W-1:0]  strap_q;
    logic [REV_W-1:0]    rev_q;
    ccr_grp_t            grp;
    logic [CACHE_AW-1:0] inv_idx;
    logic [7:0]          settle_cnt;

    ccr_mem_if #(.AW(CACHE_AW)) mem_bus ();

    // ------------------------------------------------------------
    // Reset pin synchroniser
    // ------------------------------------------------------------
    // Two flops; only the second is used downstream
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= i_reset_pin;
            rst_sync <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    // Next state; the single reset pin is the only reset source
    always_comb begin
        next_state = state;
        if (rst_sync) begin
            next_state = (state == ST_INVAL && inv_idx != IDX_LAST) ? ST_INVAL :
                         (state == ST_INVAL || state == ST_HOLD) ? ST_HOLD : ST_INVAL;
        end else begin
            case (state)
                ST_INVAL:  next_state = (inv_idx == IDX_LAST) ? ST_HOLD : ST_INVAL;
                ST_HOLD:   next_state = ST_SETTLE;
                ST_SETTLE: next_state = (i_pll_locked && settle_cnt == SETTLE_LAST) ?
                                        ST_RUN : ST_SETTLE;
                ST_RUN:    next_state = ST_RUN;
                default:   next_state = ST_INVAL;
            endcase
        end
    end

    // State register
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            state <= ST_INVAL;
        end else begin
            state <= next_state;
        end
    end

    // Cache invalidation walk, restarted by every reset entry
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            inv_idx <= '0;
        end else if (next_state == ST_INVAL && state != ST_INVAL) begin
            inv_idx <= '0;
        end else if (state == ST_INVAL && inv_idx != IDX_LAST) begin
            inv_idx <= inv_idx + 1'b1;
        end
    end

    // PLL settle counter, restarts while the PLL is out of lock
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            settle_cnt <= '0;
        end else if (state != ST_SETTLE || !i_pll_locked) begin
            settle_cnt <= '0;
        end else if (settle_cnt != SETTLE_LAST) begin
            settle_cnt <= settle_cnt + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Strap capture and ratio decode
    // ------------------------------------------------------------
    // Straps and revision latched only while held in reset
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            strap_q <= STRAP_RST;
            rev_q   <= REV_RST;
        end else if (state == ST_INVAL || state == ST_HOLD) begin
            strap_q <= i_core_ratio_straps;
            rev_q   <= i_device_identity_reg;
        end
    end

    // Revision group from the identity value range
    always_comb begin
        if (rev_q >= REV_LATE_MIN) begin
            grp = CCR_GRP_LATE;
        end else if (rev_q >= REV_MID_MIN) begin
            grp = CCR_GRP_MIDDLE;
        end else begin
            grp = CCR_GRP_EARLY;
        end
    end

    // Multiplier for the PLL referenced to the PCI-synchronous clock
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_pll_mult       <= MULT_RST;
            o_pll_ratio_test <= 1'b0;
            o_pci_ref_sel    <= 1'b0;
        end else begin
            o_pll_mult       <= ccr_decode(grp, strap_q);
            o_pll_ratio_test <= (grp == CCR_GRP_LATE) ? (strap_q == STRAP_TEST) :
                                (strap_q[1:0] == STRAP_TEST[1:0]);
            o_pci_ref_sel    <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reset outputs and cache access
    // ------------------------------------------------------------
    // Core and peripherals leave reset together
    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            o_core_resetn   <= 1'b0;
            o_periph_resetn <= 1'b0;
            o_inval_busy    <= 1'b1;
        end else begin
            o_core_resetn   <= (next_state == ST_RUN);
            o_periph_resetn <= (next_state == ST_RUN);
            o_inval_busy    <= (next_state == ST_INVAL);
        end
    end

    // Invalidation owns the write port; fills only when running
    assign mem_bus.we    = (state == ST_INVAL) || (state == ST_RUN && i_fill_we);
    assign mem_bus.waddr = (state == ST_INVAL) ? inv_idx : i_fill_idx;
    assign mem_bus.wdata = (state != ST_INVAL);
    assign mem_bus.raddr = i_lookup_idx;
    assign o_lookup_valid = mem_bus.rdata;

    ccr_valid_mem #(
        .LINES (CACHE_LINES),
        .AW    (CACHE_AW)
    ) u_valid (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .bus      (mem_bus.mem)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_pin_sync_edge: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ($past(i_resetn) && $past(i_resetn, 2) && $past(i_reset_pin, 2)) |-> rst_sync)
        else $error("reset pin not seen two edges later");

    a_reset_aborts: assert property (@(posedge i_clk) disable iff (!i_resetn)
        rst_sync |=> (!o_core_resetn && !o_periph_resetn))
        else $error("core left running during reset");

    a_inval_walk: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (state == ST_INVAL) |-> (mem_bus.we && !mem_bus.wdata && mem_bus.waddr == inv_idx))
        else $error("invalidation not clearing entries");

    a_settle_wait: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (state == ST_RUN && $past(state) == ST_SETTLE) |->
        ($past(i_pll_locked) && $past(settle_cnt) == SETTLE_LAST))
        else $error("core released before pll settled");

    a_strap_hold: assert property (@(posedge i_clk) disable iff (!i_resetn)
        ($past(state) == ST_RUN && state == ST_RUN) |-> $stable(strap_q))
        else $error("straps sampled outside reset");

    a_early_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (grp == CCR_GRP_EARLY && strap_q[1:0] == 2'h3) |=> (o_pll_mult == 4'h5))
        else $error("early group code 11 not x5");

    a_middle_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (grp == CCR_GRP_MIDDLE && strap_q[1:0] == 2'h3) |=> (o_pll_mult == 4'h8))
        else $error("middle group code 11 not x8");

    a_late_decode: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (grp == CCR_GRP_LATE && strap_q == 3'h1) |=> (o_pll_mult == 4'hA))
        else $error("late group code 001 not x10");

    a_msb_ignored: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (grp != CCR_GRP_LATE && strap_q == 3'h4) |=> (o_pll_ratio_test && o_pll_mult == 4'h4))
        else $error("top strap bit used in early revisions");

    a_group_range: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rev_q < REV_MID_MIN) |-> (grp == CCR_GRP_EARLY))
        else $error("low revision not early group");

    a_mult_bound: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (grp != CCR_GRP_LATE) |=> (o_pll_mult <= 4'(MAX_MULT)))
        else $error("multiplier above eight");

    a_joint_release: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(o_core_resetn) |-> ($rose(o_periph_resetn) && !o_inval_busy))
        else $error("core and peripherals released apart");

    a_ref_common: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $past(i_resetn) |-> o_pci_ref_sel)
        else $error("pll reference not the pci clock");

endmodule // ccr_top
`default_nettype wire

// >>> verification/ccr_board_model.sv
// Board PLL lock and system reset logic model
`timescale 1ns/1ps
`default_nettype none
module ccr_board_model #(
    parameter int PULSE_CYC = 4,
    parameter int LOCK_CYC  = 20
) (
    // Clock and command from the bench
    input  wire logic i_clk,
    input  wire logic i_pulse,
    // Board outputs
    output logic      o_reset_pin,
    output logic      o_pll_locked
);
    logic [7:0] cnt = 8'h00;

    // Reset pulse, then PLL relock time; clock itself is left running steady
    always @(posedge i_clk) begin
        if (i_pulse) begin
            cnt <= 8'(PULSE_CYC + LOCK_CYC);
        end else if (cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end
    end

    // Pin high first, lock lost until the count runs out
    assign o_reset_pin  = (cnt > 8'(LOCK_CYC));
    assign o_pll_locked = (cnt == 8'h00);
endmodule // ccr_board_model
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for the core clock ratio and reset block
`timescale 1ns/1ps
`default_nettype none
module tb;
    import ccr_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    localparam logic [REV_W-1:0] REV_MID  = 8'h20;
    localparam logic [REV_W-1:0] REV_LATE = 8'h40;
    logic               clk      = 1'b0;
    logic               resetn   = 1'b0;
    logic [STRAP_W-1:0] straps   = 3'h0;
    logic [REV_W-1:0]   rev      = 8'h00;
    logic               fill_we  = 1'b0;
    logic [5:0]         fill_idx = 6'h00;
    logic [5:0]         look_idx = 6'h00;
    logic               pulse    = 1'b0;
    wire logic          pin;
    wire logic          locked;
    logic [MULT_W-1:0]  mult;
    logic               test_flag, ref_sel, core_n, periph_n, busy, look_v;
    int                 mismatches = 0;
    int                 compares   = 0;
    int                 n;

    // Clock, 100 ns period
    always #50 clk = ~clk;

    // Lock held off long enough to still be lost when the settle phase opens
    ccr_board_model #(.LOCK_CYC(100)) board (.i_clk(clk), .i_pulse(pulse), .o_reset_pin(pin),
                                             .o_pll_locked(locked));

    ccr_top #(.REV_MID_MIN(REV_MID), .REV_LATE_MIN(REV_LATE)) uut (
        .i_clk(clk), .i_resetn(resetn), .i_reset_pin(pin),
        .i_core_ratio_straps(straps), .i_device_identity_reg(rev),
        .i_pll_locked(locked), .i_fill_we(fill_we), .i_fill_idx(fill_idx),
        .i_lookup_idx(look_idx), .o_pll_mult(mult), .o_pll_ratio_test(test_flag),
        .o_pci_ref_sel(ref_sel), .o_core_resetn(core_n), .o_periph_resetn(periph_n),
        .o_inval_busy(busy), .o_lookup_valid(look_v));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic step(input int k);
        repeat (k) @(posedge clk);
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    // Count edges until the core leaves reset, bounded
    task automatic wait_run(output int k);
        k = 0;
        while (core_n !== 1'b1 && k < 400) begin
            @(posedge clk);
            #1;
            k++;
        end
    endtask

    // Expected multiplier per group: 0 early, 1 middle, 2 late
    function automatic logic [3:0] exp_mult(input int g, input logic [2:0] c);
        logic [3:0] t_e [4];
        logic [3:0] t_m [4];
        logic [3:0] t_l [8];
        t_e = '{4'h4, 4'h6, 4'h7, 4'h5};
        t_m = '{4'h4, 4'h6, 4'h7, 4'h8};
        t_l = '{4'h4, 4'hA, 4'h9, 4'h5, 4'h4, 4'h6, 4'h7, 4'h8};
        if (g == 0) return t_e[c[1:0]];
        if (g == 1) return t_m[c[1:0]];
        return t_l[c];
    endfunction

    // Power reset with given identity and straps, then run to core release
    task automatic power_reset(input logic [7:0] r, input logic [2:0] s, output int k);
        step(1);
        resetn <= 1'b0;
        rev    <= r;
        straps <= s;
        step(3);
        #1;
        chk(8'(core_n), 8'h00);
        chk(8'(periph_n), 8'h00);
        chk(8'(busy), 8'h01);
        chk(8'(mult), 8'h04);
        chk(8'(ref_sel), 8'h00);
        step(1);
        resetn <= 1'b1;
        wait_run(k);
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    // Every strap code under every revision group, at group boundaries
    task automatic sc_decode_all();
        logic [7:0] revs [4];
        int         grp [4];
        logic [2:0] c;
        revs = '{REV_MID - 8'h01, REV_MID, REV_LATE - 8'h01, REV_LATE};
        grp  = '{0, 1, 1, 2};
        for (int i = 0; i < 4; i++) begin
            for (int j = 0; j < 8; j++) begin
                c = 3'(j);
                power_reset(revs[i], c, n);
                chk(8'(n >= 164 && n <= 172), 8'h01);
                chk(8'(mult), 8'(exp_mult(grp[i], c)));
                chk(8'(test_flag), 8'((grp[i] == 2) ? (c == 3'h0) : (c[1:0] == 2'h0)));
                chk(8'(periph_n), 8'h01);
                chk(8'(ref_sel), 8'h01);
            end
        end
    endtask

    // Fills, frozen straps in run, then a pin reset that clears the cache and relocks the PLL
    task automatic sc_pin_reset();
        step(1);
        fill_we  <= 1'b1;
        fill_idx <= 6'h05;
        step(1);
        fill_idx <= 6'h06;
        look_idx <= 6'h05;
        step(1);
        fill_we  <= 1'b0;
        step(1);
        #1;
        chk(8'(look_v), 8'h01);
        step(1);
        look_idx <= 6'h07;
        straps   <= 3'h1;
        step(2);
        #1;
        chk(8'(look_v), 8'h00);
        chk(8'(mult), 8'h08);
        step(1);
        pulse <= 1'b1;
        step(1);
        pulse <= 1'b0;
        step(2);
        #1;
        chk(8'(core_n), 8'h01);
        step(1);
        #1;
        chk(8'(core_n), 8'h00);
        chk(8'(busy), 8'h01);
        wait_run(n);
        // Walk 64, hold 1, lock back 101 edges into the wait, then 100 locked edges
        chk(8'(n), 8'hC9);
        chk(8'(mult), 8'h0A);
        step(1);
        look_idx <= 6'h05;
        step(2);
        #1;
        chk(8'(look_v), 8'h00);
    endtask

    // ------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------
    task automatic report_and_stop();
        if (mismatches == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        step(12);
        resetn <= 1'b1;
        wait_run(n);
        sc_decode_all();
        sc_pin_reset();
        report_and_stop();
    end

    // Watchdog, well beyond the expected run
    initial begin
        step(20000);
        mismatches++;
        report_and_stop();
    end
endmodule // tb
`default_nettype wire
